// >>> rtl/dmch_defines.svh
// Constants for the digital-input module command and host watchdog block
// Contract
// - Protocol digit: 0 ASCII, 1 Modbus RTU
// - Store new protocol; applies next power-on
// - Accept replies !addr, reject replies ?addr
// - Broadcast host-OK restarts watchdog, no reply
// - Status code 00, 04, 80 or 84
// - Status kept nonvolatile; only clear command clears
// - Watchdog read: enable digit and tick count
// - Set watchdog: enable digit, ticks 01..FF
// - Expiry sets timeout status, LED flashes
// - After expiry read shows disabled, same interval
// - Clear command clears timeout, stops LED, accepts
// - Modbus variant boots stored protocol unless strap init
// - Strap init at power-on forces ASCII mode
// - Function 01 selects inputs, latch-high, latch-low
// - Function 01 reply: count 1, bitmap
// - Function 02 reply: count 1, input bitmap
// - Function 03: 2N bytes, saturating counters
// - Failure: function with top bit, exception code
`ifndef DMCH_DEFINES_SVH
`define DMCH_DEFINES_SVH

`define DMCH_CLK_PERIOD_NS 25
`define DMCH_TICK_NS 100000000
`define DMCH_FLASH_TICKS 5
`define DMCH_BOOT_WAIT 2'h2
`define DMCH_PROTO_ASCII 4'h0
`define DMCH_PROTO_MODBUS 4'h1
`define DMCH_DIGIT_OFF 4'h0
`define DMCH_DIGIT_ON 4'h1
`define DMCH_SS_EN_BIT 7
`define DMCH_SS_TO_BIT 2
`define DMCH_FC_COILS 8'h01
`define DMCH_FC_INPUTS 8'h02
`define DMCH_FC_COUNTS 8'h03
`define DMCH_FC_EXC_BIT 8'h80
`define DMCH_EXC_FUNC 8'h01
`define DMCH_EXC_ADDR 8'h02
`define DMCH_EXC_VALUE 8'h03
`define DMCH_BASE_DI 13'h0004
`define DMCH_BASE_LHI 13'h0008
`define DMCH_BASE_LLO 13'h000C
`define DMCH_BASE_CNT 13'h0000
`define DMCH_HOST_OK_REG 16'h3038
`define DMCH_MAX_QTY 17'h0_0008
`define DMCH_SAT_MAX 16'hFFFF
`define DMCH_BCAST_ADDR 8'h00

`endif

// >>> rtl/dmch_pkg.sv
// Types for the digital-input module command and host watchdog block
package dmch_pkg;

  typedef enum logic [2:0] {
    cmd_set_protocol,
    cmd_read_status,
    cmd_clear_status,
    cmd_read_wdog,
    cmd_set_wdog,
    cmd_host_ok
  } dmch_cmd_t;

endpackage : dmch_pkg

// >>> rtl/dmch_top.sv
// Command interpreter, host watchdog and Modbus read handling
`timescale 1ns/1ps
`include "dmch_defines.svh"
`default_nettype none

module dmch_top
  import dmch_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter bit MODBUS_VARIANT = 1'b1,
  parameter int TICK_CYCLES = `DMCH_TICK_NS / `DMCH_CLK_PERIOD_NS,
  parameter int FLASH_TICKS = `DMCH_FLASH_TICKS
)
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic init_strap_n_in,
  input wire logic [7:0] di_in,
  input wire logic [7:0] module_address_in,
  input wire logic nv_protocol_in,
  input wire logic nv_wd_en_in,
  input wire logic [7:0] nv_wd_ticks_in,
  input wire logic nv_timeout_in,
  input wire logic ascii_valid_in,
  input wire dmch_cmd_t ascii_cmd_in,
  input wire logic [7:0] ascii_addr_in,
  input wire logic [3:0] ascii_digit_in,
  input wire logic [7:0] ascii_value_in,
  input wire logic mb_valid_in,
  input wire logic [7:0] mb_addr_in,
  input wire logic [7:0] mb_func_in,
  input wire logic [15:0] mb_start_in,
  input wire logic [15:0] mb_qty_in,
  output logic ready_out,
  output logic active_modbus_out,
  output logic rsp_valid_out,
  output logic rsp_modbus_out,
  output logic rsp_ok_out,
  output logic [7:0] rsp_addr_out,
  output logic [7:0] rsp_code_out,
  output logic [7:0] rsp_count_out,
  output logic [127:0] rsp_data_out,
  output logic nv_wr_out,
  output logic nv_protocol_out,
  output logic nv_wd_en_out,
  output logic [7:0] nv_wd_ticks_out,
  output logic nv_timeout_out,
  output logic led_out
);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int FLASH_W = $clog2(FLASH_TICKS + 1);
  // Picks qty channels starting at off, channel off lands in bit 0
  function automatic logic [7:0] sel_bits(input logic [7:0] src, input logic [2:0] off,
                                          input logic [15:0] qty);
    logic [7:0] mask;
    mask = 8'hFF >> (4'h8 - qty[3:0]);
    sel_bits = (src >> off) & mask;
  endfunction : sel_bits
  // Count from 1 to 8 and not past the last channel
  function automatic logic range_ok(input logic [2:0] off, input logic [15:0] qty);
    logic [16:0] last;
    last = {14'h0, off} + {1'b0, qty};
    range_ok = (qty != 16'h0) && (last <= `DMCH_MAX_QTY);
  endfunction : range_ok
  logic strap_s1_reg, strap_s2_reg, ready_reg, active_modbus_reg, protocol_reg;
  logic wd_en_reg, timeout_reg, led_reg, nv_wr_reg;
  logic rsp_valid_reg, rsp_modbus_reg, rsp_ok_reg;
  logic [1:0] boot_cnt_reg;
  logic [7:0] di_s1_reg, di_s2_reg, di_prev_reg, wd_ticks_reg, elapsed_reg;
  logic [7:0] latch_hi_reg, latch_lo_reg, rsp_addr_reg, rsp_code_reg, rsp_count_reg;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic [FLASH_W-1:0] flash_cnt_reg;
  logic [15:0] cnt_reg [0:7];
  logic [127:0] rsp_data_reg;
  logic strap_init, tick, boot_load, ascii_take, ascii_mine, ascii_good, set_proto_ok;
  logic set_wdog_ok, clear_ok, mb_take, mb_reply, mb_host_ok, mb_exc, kick, expire;
  logic [7:0] mb_code, mb_count, status_code;
  logic [127:0] mb_data;
  assign strap_init = ~strap_s2_reg;
  assign boot_load = !ready_reg && (boot_cnt_reg == `DMCH_BOOT_WAIT);
  assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));
  assign ascii_take = ready_reg && !active_modbus_reg && ascii_valid_in;
  assign ascii_mine = ascii_take && (ascii_cmd_in != cmd_host_ok)
                      && (ascii_addr_in == module_address_in);
  assign mb_take = ready_reg && active_modbus_reg && mb_valid_in;
  always_comb
  begin
    ascii_good = 1'b1;
    case (ascii_cmd_in)
      cmd_set_protocol:
        ascii_good = MODBUS_VARIANT && strap_init
                     && (ascii_digit_in == `DMCH_PROTO_ASCII
                         || ascii_digit_in == `DMCH_PROTO_MODBUS);
      cmd_set_wdog:
        ascii_good = (ascii_digit_in == `DMCH_DIGIT_OFF
                      || ascii_digit_in == `DMCH_DIGIT_ON)
                     && (ascii_value_in != 8'h00);
      default: ascii_good = 1'b1;
    endcase
  end
  assign set_proto_ok = ascii_mine && ascii_good && (ascii_cmd_in == cmd_set_protocol);
  assign set_wdog_ok = ascii_mine && ascii_good && (ascii_cmd_in == cmd_set_wdog);
  assign clear_ok = ascii_mine && (ascii_cmd_in == cmd_clear_status);
  assign kick = (ascii_take && ascii_cmd_in == cmd_host_ok) || mb_host_ok
                || set_wdog_ok;
  assign expire = tick && wd_en_reg && !kick && (wd_ticks_reg != 8'h00)
                  && (elapsed_reg == wd_ticks_reg - 8'h01);
  assign status_code = (8'(wd_en_reg) << `DMCH_SS_EN_BIT)
                       | (8'(timeout_reg) << `DMCH_SS_TO_BIT);
  always_comb
  begin
    mb_reply = 1'b0;
    mb_host_ok = 1'b0;
    mb_exc = 1'b0;
    mb_code = mb_func_in;
    mb_count = 8'h00;
    mb_data = 128'h0;
    if (mb_take && (mb_addr_in == `DMCH_BCAST_ADDR || mb_addr_in == module_address_in))
    begin
      mb_reply = (mb_addr_in != `DMCH_BCAST_ADDR);
      if (mb_func_in == `DMCH_FC_COILS)
      begin
        mb_count = 8'h01;
        if (mb_qty_in == 16'h0 || mb_qty_in > 16'h0008)
          mb_exc = 1'b1;
        else if (!range_ok(mb_start_in[2:0], mb_qty_in))
          mb_exc = 1'b1;
        else if (mb_start_in[15:3] == `DMCH_BASE_DI)
          mb_data[7:0] = sel_bits(di_s2_reg, mb_start_in[2:0], mb_qty_in);
        else if (mb_start_in[15:3] == `DMCH_BASE_LHI)
          mb_data[7:0] = sel_bits(latch_hi_reg, mb_start_in[2:0], mb_qty_in);
        else if (mb_start_in[15:3] == `DMCH_BASE_LLO)
          mb_data[7:0] = sel_bits(latch_lo_reg, mb_start_in[2:0], mb_qty_in);
        else
          mb_exc = 1'b1;
        if (mb_exc)
          mb_data[7:0] = (mb_qty_in == 16'h0 || mb_qty_in > 16'h0008) ?
                         `DMCH_EXC_VALUE : `DMCH_EXC_ADDR;
      end
      else if (mb_func_in == `DMCH_FC_INPUTS)
      begin
        mb_count = 8'h01;
        if (mb_qty_in == 16'h0 || mb_qty_in > 16'h0008)
        begin
          mb_exc = 1'b1;
          mb_data[7:0] = `DMCH_EXC_VALUE;
        end
        else if (mb_start_in[15:3] != `DMCH_BASE_CNT
                 || !range_ok(mb_start_in[2:0], mb_qty_in))
        begin
          mb_exc = 1'b1;
          mb_data[7:0] = `DMCH_EXC_ADDR;
        end
        else
          mb_data[7:0] = sel_bits(di_s2_reg, mb_start_in[2:0], mb_qty_in);
      end
      else if (mb_func_in == `DMCH_FC_COUNTS)
      begin
        if (mb_start_in == `DMCH_HOST_OK_REG)
        begin
          mb_host_ok = 1'b1;
          mb_reply = 1'b0;
        end
        else if (mb_qty_in == 16'h0 || mb_qty_in > 16'h0008)
        begin
          mb_exc = 1'b1;
          mb_data[7:0] = `DMCH_EXC_VALUE;
        end
        else if (mb_start_in[15:3] != `DMCH_BASE_CNT
                 || !range_ok(mb_start_in[2:0], mb_qty_in))
        begin
          mb_exc = 1'b1;
          mb_data[7:0] = `DMCH_EXC_ADDR;
        end
        else
        begin
          mb_count = {3'h0, mb_qty_in[3:0], 1'b0};
          for (int i = 0; i < 8; i++)
          begin
            if (mb_qty_in > 16'(i))
              mb_data[16*i +: 16] = {cnt_reg[3'(mb_start_in[2:0] + 3'(i))][7:0],
                                     cnt_reg[3'(mb_start_in[2:0] + 3'(i))][15:8]};
          end
        end
      end
      else
      begin
        mb_exc = 1'b1;
        mb_data[7:0] = `DMCH_EXC_FUNC;
      end
      if (mb_exc)
      begin
        mb_code = mb_func_in | `DMCH_FC_EXC_BIT;
        mb_count = 8'h00;
      end
    end
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      strap_s1_reg <= 1'b1;
      strap_s2_reg <= 1'b1;
      di_s1_reg <= 8'h00;
      di_s2_reg <= 8'h00;
    end
    else
    begin
      strap_s1_reg <= init_strap_n_in;
      strap_s2_reg <= strap_s1_reg;
      di_s1_reg <= di_in;
      di_s2_reg <= di_s1_reg;
    end
  end
  // Power-on sequencing and mode selection
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      boot_cnt_reg <= 2'h0;
      ready_reg <= 1'b0;
      active_modbus_reg <= 1'b0;
    end
    else if (!ready_reg)
    begin
      boot_cnt_reg <= boot_cnt_reg + 2'h1;
      if (boot_load)
      begin
        ready_reg <= 1'b1;
        active_modbus_reg <= MODBUS_VARIANT && !strap_init
                             && nv_protocol_in;
      end
    end
  end
  // Stored protocol choice, only read back at the next power-on
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      protocol_reg <= 1'b0;
    else if (boot_load)
      protocol_reg <= nv_protocol_in;
    else if (set_proto_ok)
      protocol_reg <= ascii_digit_in[0];
  end
  // Watchdog settings and timeout status
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      wd_en_reg <= 1'b0;
      wd_ticks_reg <= 8'h00;
      timeout_reg <= 1'b0;
    end
    else if (boot_load)
    begin
      wd_en_reg <= nv_wd_en_in;
      wd_ticks_reg <= nv_wd_ticks_in;
      timeout_reg <= nv_timeout_in;
    end
    else
    begin
      if (set_wdog_ok)
      begin
        wd_en_reg <= ascii_digit_in[0];
        wd_ticks_reg <= ascii_value_in;
      end
      else if (expire)
        wd_en_reg <= 1'b0;
      if (expire)
        timeout_reg <= 1'b1;
      else if (clear_ok)
        timeout_reg <= 1'b0;
    end
  end
  // Tenth-second tick and elapsed tick count
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in || kick)
    begin
      tick_cnt_reg <= '0;
      elapsed_reg <= 8'h00;
    end
    else
    begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + TICK_W'(1);
      if (tick && wd_en_reg)
        elapsed_reg <= expire ? 8'h00 : elapsed_reg + 8'h01;
    end
  end
  // LED flashes while timeout status is set
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in || !timeout_reg)
    begin
      flash_cnt_reg <= '0;
      led_reg <= 1'b0;
    end
    else if (tick)
    begin
      if (flash_cnt_reg == FLASH_W'(FLASH_TICKS - 1))
      begin
        flash_cnt_reg <= '0;
        led_reg <= ~led_reg;
      end
      else
        flash_cnt_reg <= flash_cnt_reg + FLASH_W'(1);
    end
  end
  // Nonvolatile write strobe after any stored value changes
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      nv_wr_reg <= 1'b0;
    else
      nv_wr_reg <= set_proto_ok || set_wdog_ok || expire || clear_ok;
  end
  // Latched inputs and saturating edge counters
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      di_prev_reg <= 8'h00;
      latch_hi_reg <= 8'h00;
      latch_lo_reg <= 8'h00;
      for (int i = 0; i < 8; i++)
        cnt_reg[i] <= 16'h0000;
    end
    else
    begin
      di_prev_reg <= di_s2_reg;
      latch_hi_reg <= latch_hi_reg | (di_s2_reg & ~di_prev_reg);
      latch_lo_reg <= latch_lo_reg | (~di_s2_reg & di_prev_reg);
      for (int i = 0; i < 8; i++)
      begin
        if (di_s2_reg[i] && !di_prev_reg[i] && cnt_reg[i] != `DMCH_SAT_MAX)
          cnt_reg[i] <= cnt_reg[i] + 16'h0001;
      end
    end
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      rsp_valid_reg <= 1'b0;
      rsp_modbus_reg <= 1'b0;
      rsp_ok_reg <= 1'b0;
      rsp_addr_reg <= 8'h00;
      rsp_code_reg <= 8'h00;
      rsp_count_reg <= 8'h00;
      rsp_data_reg <= 128'h0;
    end
    else
    begin
      rsp_valid_reg <= ascii_mine || mb_reply;
      rsp_addr_reg <= module_address_in;
      if (ascii_mine)
      begin
        rsp_modbus_reg <= 1'b0;
        rsp_ok_reg <= ascii_good;
        rsp_count_reg <= 8'h00;
        rsp_data_reg <= {120'h0, wd_ticks_reg};
        if (ascii_cmd_in == cmd_read_status)
          rsp_code_reg <= status_code;
        else if (ascii_cmd_in == cmd_read_wdog)
          rsp_code_reg <= {7'h00, wd_en_reg};
        else
          rsp_code_reg <= 8'h00;
      end
      else
      begin
        rsp_modbus_reg <= 1'b1;
        rsp_ok_reg <= !mb_exc;
        rsp_code_reg <= mb_code;
        rsp_count_reg <= mb_count;
        rsp_data_reg <= mb_data;
      end
    end
  end
  assign ready_out = ready_reg;
  assign active_modbus_out = active_modbus_reg;
  assign rsp_valid_out = rsp_valid_reg;
  assign rsp_modbus_out = rsp_modbus_reg;
  assign rsp_ok_out = rsp_ok_reg;
  assign rsp_addr_out = rsp_addr_reg;
  assign rsp_code_out = rsp_code_reg;
  assign rsp_count_out = rsp_count_reg;
  assign rsp_data_out = rsp_data_reg;
  assign nv_wr_out = nv_wr_reg;
  assign nv_protocol_out = protocol_reg;
  assign nv_wd_en_out = wd_en_reg;
  assign nv_wd_ticks_out = wd_ticks_reg;
  assign nv_timeout_out = timeout_reg;
  assign led_out = led_reg;
endmodule : dmch_top

`default_nettype wire

// >>> tb/dmch_top_monitor.sv
// Assertion checker for the command and watchdog block
`timescale 1ns/1ps
`default_nettype none

module dmch_top_monitor
  import dmch_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic init_strap_n_in,
  input wire logic [7:0] di_in,
  input wire logic [7:0] module_address_in,
  input wire logic nv_protocol_in,
  input wire logic nv_wd_en_in,
  input wire logic [7:0] nv_wd_ticks_in,
  input wire logic nv_timeout_in,
  input wire logic ascii_valid_in,
  input wire dmch_cmd_t ascii_cmd_in,
  input wire logic [7:0] ascii_addr_in,
  input wire logic [3:0] ascii_digit_in,
  input wire logic [7:0] ascii_value_in,
  input wire logic mb_valid_in,
  input wire logic [7:0] mb_addr_in,
  input wire logic [7:0] mb_func_in,
  input wire logic [15:0] mb_start_in,
  input wire logic [15:0] mb_qty_in,
  input wire logic ready_out,
  input wire logic active_modbus_out,
  input wire logic rsp_valid_out,
  input wire logic rsp_modbus_out,
  input wire logic rsp_ok_out,
  input wire logic [7:0] rsp_addr_out,
  input wire logic [7:0] rsp_code_out,
  input wire logic [7:0] rsp_count_out,
  input wire logic [127:0] rsp_data_out,
  input wire logic nv_wr_out,
  input wire logic nv_protocol_out,
  input wire logic nv_wd_en_out,
  input wire logic [7:0] nv_wd_ticks_out,
  input wire logic nv_timeout_out,
  input wire logic led_out
);
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  wire asc_take = ascii_valid_in && ready_out && !active_modbus_out;
  wire asc_own = asc_take && ascii_addr_in == module_address_in;
  wire mb_own = mb_valid_in && ready_out && active_modbus_out && mb_addr_in == module_address_in;
  wire mb_fit = mb_qty_in != 16'h0000 && mb_qty_in <= 16'h0008
    && {13'h0000, mb_start_in[2:0]} + mb_qty_in <= 16'h0008;

  a_ascii_reply_own: assert property (
    asc_own && ascii_cmd_in != cmd_host_ok |=> rsp_valid_out && !rsp_modbus_out
      && rsp_addr_out == module_address_in)
    else $error("ascii reply missing");
  a_host_ok_silent: assert property (
    asc_take && ascii_cmd_in == cmd_host_ok |=> !rsp_valid_out)
    else $error("host ok answered");
  a_mode_held: assert property (
    ready_out && $past(ready_out) |-> $stable(active_modbus_out))
    else $error("mode changed after boot");
  a_status_code: assert property (
    rsp_valid_out && !rsp_modbus_out && rsp_ok_out && $past(ascii_cmd_in == cmd_read_status)
      |-> rsp_code_out == {$past(nv_wd_en_out), 4'h0, $past(nv_timeout_out), 2'b00})
    else $error("status code wrong");
  a_bitmap_count: assert property (
    mb_own && mb_fit && (mb_func_in == 8'h02 && mb_start_in <= 16'h0007
      || mb_func_in == 8'h01 && mb_start_in inside {[16'h0020:16'h0027],
      [16'h0040:16'h0047], [16'h0060:16'h0067]})
      |=> rsp_valid_out && rsp_ok_out && rsp_count_out == 8'h01)
    else $error("bitmap reply count wrong");
  a_counter_count: assert property (
    mb_own && mb_func_in == 8'h03 && mb_fit && mb_start_in <= 16'h0007
      |=> rsp_valid_out && rsp_ok_out && rsp_count_out == 8'($past(mb_qty_in) * 2))
    else $error("counter reply count wrong");
  a_exc_form: assert property (
    rsp_valid_out && rsp_modbus_out && !rsp_ok_out |-> rsp_code_out[7]
      && rsp_count_out == 8'h00 && rsp_data_out[7:0] inside {8'h01, 8'h02, 8'h03})
    else $error("exception reply malformed");
  a_exc_func: assert property (
    mb_own && !(mb_func_in inside {8'h01, 8'h02, 8'h03})
      |=> rsp_valid_out && !rsp_ok_out && rsp_code_out == ($past(mb_func_in) | 8'h80))
    else $error("unknown function not refused");
  a_led_quiet: assert property (
    !nv_timeout_out && !$past(nv_timeout_out) |-> !led_out)
    else $error("led active without timeout");
  a_timeout_sticky: assert property (
    $past(nv_timeout_out) && !nv_timeout_out |-> $past(asc_own && ascii_cmd_in == cmd_clear_status))
    else $error("timeout cleared without command");
endmodule : dmch_top_monitor

bind dmch_top dmch_top_monitor u_dmch_top_monitor (.*);

`default_nettype wire

// >>> tb/dmch_host_model.sv
// Remote host model issuing parsed commands and requests
`timescale 1ns/1ps
`default_nettype none

module dmch_host_model
  import dmch_pkg::*;
(
  input wire logic clk_in,
  output logic ascii_valid_out,
  output dmch_cmd_t ascii_cmd_out,
  output logic [7:0] ascii_addr_out,
  output logic [3:0] ascii_digit_out,
  output logic [7:0] ascii_value_out,
  output logic mb_valid_out,
  output logic [7:0] mb_addr_out,
  output logic [7:0] mb_func_out,
  output logic [15:0] mb_start_out,
  output logic [15:0] mb_qty_out
);
  initial
  begin
    ascii_valid_out = 1'b0;
    ascii_cmd_out = cmd_read_status;
    {ascii_addr_out, ascii_digit_out, ascii_value_out} = 20'h5_A5A5;
    mb_valid_out = 1'b0;
    {mb_addr_out, mb_func_out, mb_start_out, mb_qty_out} = 48'hA5A5_A5A5_A5A5;
  end

  // One command pulse; address, digit and value scrambled once released, command kept
  task automatic ascii(input dmch_cmd_t c, input logic [7:0] a, input logic [3:0] d,
    input logic [7:0] v);
    @(posedge clk_in);
    ascii_valid_out <= 1'b1;
    ascii_cmd_out <= c; // host ok sent to address a like any other command
    ascii_addr_out <= a;
    ascii_digit_out <= d;
    ascii_value_out <= v;
    @(posedge clk_in);
    ascii_valid_out <= 1'b0;
    {ascii_addr_out, ascii_digit_out, ascii_value_out} <= ~{a, d, v};
  endtask : ascii

  // One request pulse; fields scrambled once released
  task automatic modbus(input logic [7:0] a, input logic [7:0] f, input logic [15:0] s,
    input logic [15:0] q);
    @(posedge clk_in);
    mb_valid_out <= 1'b1;
    {mb_addr_out, mb_func_out, mb_start_out, mb_qty_out} <= {a, f, s, q};
    @(posedge clk_in);
    mb_valid_out <= 1'b0;
    {mb_addr_out, mb_func_out, mb_start_out, mb_qty_out} <= ~{a, f, s, q};
  endtask : modbus
endmodule : dmch_host_model

`default_nettype wire

// >>> tb/dmch_top_test.sv
// Testbench for the command interpreter and host watchdog
`timescale 1ns/1ps
`default_nettype none

module dmch_top_test;
  import dmch_pkg::*;
  localparam logic [7:0] own = 8'h05;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic strap_n = 1'b0;
  logic [7:0] di = 8'h00;
  logic st_proto = 1'b0;
  logic st_en = 1'b0;
  logic st_to = 1'b0;
  logic [7:0] st_ticks = 8'h00;
  logic a_v, m_v, ready, act, rv, rm, rok, nv_wr, nv_p, nv_en, nv_to, led, led_seen;
  dmch_cmd_t a_c;
  logic [3:0] a_d;
  logic [7:0] a_a, a_val, m_a, m_f, raddr, rcode, rcnt, nv_tk;
  logic [15:0] m_s, m_q;
  logic [127:0] rdata;
  int mismatches = 0;
  int num_checks = 0;

  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Nonvolatile store fed back at boot
  always @(posedge sys_clk)
    if (nv_wr) {st_proto, st_en, st_ticks, st_to} <= {nv_p, nv_en, nv_tk, nv_to};

  dmch_host_model u_dmch_host_model (.clk_in(sys_clk), .ascii_valid_out(a_v),
    .ascii_cmd_out(a_c), .ascii_addr_out(a_a), .ascii_digit_out(a_d),
    .ascii_value_out(a_val), .mb_valid_out(m_v), .mb_addr_out(m_a), .mb_func_out(m_f),
    .mb_start_out(m_s), .mb_qty_out(m_q));

  dmch_top #(.TICK_CYCLES(10), .FLASH_TICKS(2)) u_dmch_top (.sys_clk_in(sys_clk),
    .reset_in(reset), .init_strap_n_in(strap_n), .di_in(di), .module_address_in(own),
    .nv_protocol_in(st_proto), .nv_wd_en_in(st_en), .nv_wd_ticks_in(st_ticks),
    .nv_timeout_in(st_to), .ascii_valid_in(a_v), .ascii_cmd_in(a_c), .ascii_addr_in(a_a),
    .ascii_digit_in(a_d), .ascii_value_in(a_val), .mb_valid_in(m_v), .mb_addr_in(m_a),
    .mb_func_in(m_f), .mb_start_in(m_s), .mb_qty_in(m_q), .ready_out(ready),
    .active_modbus_out(act), .rsp_valid_out(rv), .rsp_modbus_out(rm), .rsp_ok_out(rok),
    .rsp_addr_out(raddr), .rsp_code_out(rcode), .rsp_count_out(rcnt), .rsp_data_out(rdata),
    .nv_wr_out(nv_wr), .nv_protocol_out(nv_p), .nv_wd_en_out(nv_en),
    .nv_wd_ticks_out(nv_tk), .nv_timeout_out(nv_to), .led_out(led));

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic do_reset(input logic strap);
    @(posedge sys_clk);
    reset <= 1'b1;
    strap_n <= strap;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 10 && ready !== 1'b1; i++) @(posedge sys_clk);
    check(ready, 1'b1);
  endtask : do_reset

  task automatic expect_rsp(input logic mbx, input logic rep, input logic ok,
    input logic [7:0] code, input logic [7:0] cnt, input logic [127:0] data, input int nb);
    logic [127:0] mask;
    mask = (128'h1 << (8 * nb)) - 128'h1;
    #1;
    check(rv, rep);
    if (rep)
    begin
      check({rm, rok, raddr, rcode, rcnt}, {mbx, ok, own, code, cnt});
      check(rdata & mask, data);
    end
  endtask : expect_rsp

  task automatic asc(input dmch_cmd_t c, input logic [7:0] a, input logic [3:0] d,
    input logic [7:0] v, input logic rep, input logic ok, input logic [7:0] code,
    input logic [7:0] data);
    u_dmch_host_model.ascii(c, a, d, v);
    expect_rsp(1'b0, rep, ok, code, 8'h00, data, (c == cmd_read_wdog) ? 1 : 0);
  endtask : asc

  task automatic mbr(input logic [7:0] a, input logic [7:0] f, input logic [15:0] s,
    input logic [15:0] q, input logic rep, input logic ok, input logic [7:0] code,
    input logic [7:0] cnt, input logic [127:0] data);
    u_dmch_host_model.modbus(a, f, s, q);
    expect_rsp(1'b1, rep, ok, code, cnt, data, ok ? cnt : 1);
  endtask : mbr

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    final_report();
  end

  initial
  begin
    do_reset(1'b0);
    check(act, 1'b0);
    asc(cmd_read_status, own, 4'h0, 8'h00, 1, 1, 8'h00, 8'h00);
    asc(cmd_read_status, 8'h06, 4'h0, 8'h00, 0, 0, 8'h00, 8'h00);
    asc(cmd_set_protocol, own, 4'h2, 8'h00, 1, 0, 8'h00, 8'h00);
    asc(cmd_set_protocol, own, 4'h1, 8'h00, 1, 1, 8'h00, 8'h00);
    repeat (3) @(posedge sys_clk);
    check({act, st_proto}, 2'b01);
    asc(cmd_set_wdog, own, 4'h1, 8'h00, 1, 0, 8'h00, 8'h00);
    asc(cmd_set_wdog, own, 4'h1, 8'h03, 1, 1, 8'h00, 8'h00);
    asc(cmd_read_wdog, own, 4'h0, 8'h00, 1, 1, 8'h01, 8'h03);
    asc(cmd_read_status, own, 4'h0, 8'h00, 1, 1, 8'h80, 8'h00);
    repeat (6)
    begin
      repeat (18) @(posedge sys_clk);
      asc(cmd_host_ok, 8'h00, 4'h0, 8'h00, 0, 0, 8'h00, 8'h00);
    end
    asc(cmd_read_status, own, 4'h0, 8'h00, 1, 1, 8'h80, 8'h00);
    led_seen = 1'b0;
    repeat (100)
    begin
      @(posedge sys_clk);
      led_seen |= led;
    end
    check(led_seen, 1'b1);
    asc(cmd_read_status, own, 4'h0, 8'h00, 1, 1, 8'h04, 8'h00);
    asc(cmd_read_wdog, own, 4'h0, 8'h00, 1, 1, 8'h00, 8'h03);
    do_reset(1'b0);
    asc(cmd_read_status, own, 4'h0, 8'h00, 1, 1, 8'h04, 8'h00);
    for (int i = 0; i < 40 && led !== 1'b1; i++) @(posedge sys_clk);
    check(led, 1'b1);
    asc(cmd_clear_status, own, 4'h0, 8'h00, 1, 1, 8'h00, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 check(led, 1'b0);
    asc(cmd_read_status, own, 4'h0, 8'h00, 1, 1, 8'h00, 8'h00);
    do_reset(1'b1);
    check(act, 1'b1);
    asc(cmd_read_status, own, 4'h0, 8'h00, 0, 0, 8'h00, 8'h00);
    repeat (3)
    begin
      @(posedge sys_clk);
      di <= 8'h01;
      repeat (4) @(posedge sys_clk);
      di <= 8'h00;
      repeat (4) @(posedge sys_clk);
    end
    di <= 8'hA5;
    repeat (6) @(posedge sys_clk);
    mbr(own, 8'h01, 16'h0020, 16'h0008, 1, 1, 8'h01, 8'h01, 8'hA5);
    mbr(own, 8'h01, 16'h0040, 16'h0008, 1, 1, 8'h01, 8'h01, 8'hA5);
    mbr(own, 8'h01, 16'h0060, 16'h0008, 1, 1, 8'h01, 8'h01, 8'h01);
    mbr(own, 8'h01, 16'h0022, 16'h0003, 1, 1, 8'h01, 8'h01, 8'h01);
    mbr(own, 8'h02, 16'h0000, 16'h0008, 1, 1, 8'h02, 8'h01, 8'hA5);
    mbr(own, 8'h02, 16'h0005, 16'h0003, 1, 1, 8'h02, 8'h01, 8'h05);
    mbr(own, 8'h03, 16'h0000, 16'h0003, 1, 1, 8'h03, 8'h06, 48'h0100_0000_0400);
    mbr(own, 8'h01, 16'h0020, 16'h0000, 1, 0, 8'h81, 8'h00, 8'h03);
    mbr(own, 8'h01, 16'h0030, 16'h0001, 1, 0, 8'h81, 8'h00, 8'h02);
    mbr(own, 8'h02, 16'h0006, 16'h0003, 1, 0, 8'h82, 8'h00, 8'h02);
    mbr(own, 8'h03, 16'h0000, 16'h0009, 1, 0, 8'h83, 8'h00, 8'h03);
    mbr(own, 8'h07, 16'h0000, 16'h0001, 1, 0, 8'h87, 8'h00, 8'h01);
    mbr(8'h00, 8'h03, 16'h3038, 16'h0000, 0, 0, 8'h00, 8'h00, 8'h00);
    final_report();
  end
endmodule : dmch_top_test

`default_nettype wire
